// File: pkg/wlv_pkg.sv
// Overview of operation
// - MR1 bit 7 enters and leaves leveling
// - Leveling: DQ termination off, ODT drives strobes
// - MR1 bit 12 disables output buffer
// - All nominal termination settings work in leveling
// - Controller disables write termination before entry
// - DQ may drive undefined on entry
// - Controller issues only deselect or MR1
// - One rank at a time, others output-off
// - ODT only after mode delay from entry
// - Strobes parked after strobe-enable delay, terminated
// - Single strobe edge after low and delay
// - Strobe rise samples CK onto DQ
// - No read strobes; DQ bits switch together
// - Feedback one for CK high, else zero
// - Sample, step delay, lock on zero-to-one
// - Strobe-enable delay covers ODT turn-on
// - Exit: stop strobes; DQ undefined until delay
// - Exit drives ODT low and keeps it
// - Clear leveling only after termination off
// - Wait cycle time and mode delay after exit
// - Each byte lane has its own feedback
package wlv_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int CK_PERIOD_NS = 160;
	localparam int CK_PER_CYC = CK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CK_HALF_CYC = CK_PER_CYC / 2;
	localparam int LANES = 2;
	localparam int DLY_W = 3;
	localparam logic [2:0] MR_SEL_MR1 = 3'h1;
	localparam logic [2:0] MR_SEL_MR2 = 3'h2;
	localparam int MR1_WL_BIT = 7;
	localparam int MR1_QOFF_BIT = 12;
	localparam int MR2_RTTWR_POS = 9;
	localparam logic [13:0] MR1_BASE = 14'h0001;
	localparam logic [13:0] MR2_BASE = 14'h0000;
	localparam int T_MOD_NCK = 24;
	localparam int T_MRD_NCK = 8;
	localparam int T_ODTON_NCK = 12;
	localparam int T_WLDQSEN_NCK = T_MOD_NCK + T_ODTON_NCK + 2;
	localparam int T_WLMRD_NCK = 40;
	localparam int T_WLO_NCK = 4;
	localparam int T_ODTOFF_NCK = 12;
	localparam int MAX_TRIES = 32;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DELAY = 8'h08;
	localparam int CTRL_START_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_FAIL_BIT = 2;
	localparam int DELAY_LANE_STRIDE = 8;
endpackage

// File: pkg/wlv_if.sv
`timescale 1ns/1ns
interface wlv_if;
	logic ck;
	logic mrsCmd;
	logic [2:0] mrSel;
	logic [13:0] mrAddr;
	logic odt;
	logic [1:0] dqsT;
	logic [1:0] dqsC;
	logic [1:0] dqsOeN;
	logic [15:0] dqOut;
	logic [1:0] dqOeN;
	logic [1:0] dqsTLine;
	logic [1:0] dqsCLine;
	logic [15:0] dqLine;
	// Undriven lines settle low through termination
	assign dqsTLine = dqsT & ~dqsOeN;
	assign dqsCLine = dqsC & ~dqsOeN;
	assign dqLine = dqOut & ~{{8{dqOeN[1]}}, {8{dqOeN[0]}}};
	modport ctrl (output ck, mrsCmd, mrSel, mrAddr, odt, dqsT, dqsC, dqsOeN, input dqLine);
	modport dram (input ck, mrsCmd, mrSel, mrAddr, odt, dqsTLine, dqsCLine, output dqOut, dqOeN);
endinterface

// File: rtl/wlv_sync.sv
`timescale 1ns/1ns
module wlv_sync #(parameter int W = 1)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// File: rtl/wlv_dram.sv
`timescale 1ns/1ns
module wlv_dram
	import wlv_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	wlv_if.dram link,
	output logic wlActive,
	output logic qOff,
	output logic dqsTermOn,
	output logic dqTermOn
);
	localparam int IN_W = 1 + 1 + 3 + 14 + 1 + 2 + 2;
	logic [IN_W-1:0] rawIn;
	logic [IN_W-1:0] syncIn;
	logic ckS, mrsS, odtS;
	logic [2:0] selS;
	logic [13:0] addrS;
	logic [1:0] dqsTS, dqsCS;
	logic ck_reg;
	logic [1:0] diff_reg;
	logic ckRise;
	logic [7:0] modCnt_reg;
	logic odtReady_reg;
	logic exitHold_reg;
	function automatic logic isMr1(input logic cmd, input logic [2:0] sel);
		isMr1 = cmd && sel == MR_SEL_MR1;
	endfunction
	assign rawIn = {link.ck, link.mrsCmd, link.mrSel, link.mrAddr, link.odt, link.dqsTLine, link.dqsCLine};
	wlv_sync #(.W(IN_W)) inSync (.mclk(mclk), .rst(rst), .ce(ce), .d(rawIn), .q(syncIn));
	assign {ckS, mrsS, selS, addrS, odtS, dqsTS, dqsCS} = syncIn;
	assign ckRise = ckS & ~ck_reg;
	always_ff @(posedge mclk)
	begin
		if (rst)
			ck_reg <= 1'b0;
		else if (ce)
			ck_reg <= ckS;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wlActive <= 1'b0;
			qOff <= 1'b0;
		end
		else if (ce && ckRise && isMr1(mrsS, selS))
		begin
			wlActive <= addrS[MR1_WL_BIT];
			qOff <= addrS[MR1_QOFF_BIT];
		end
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			modCnt_reg <= 8'h00;
			odtReady_reg <= 1'b0;
			exitHold_reg <= 1'b0;
		end
		else if (ce && ckRise)
		begin
			if (isMr1(mrsS, selS))
			begin
				modCnt_reg <= 8'(T_MOD_NCK);
				odtReady_reg <= 1'b0;
				exitHold_reg <= wlActive & ~addrS[MR1_WL_BIT];
			end
			else if (modCnt_reg != 8'h00)
				modCnt_reg <= modCnt_reg - 8'h01;
			else
			begin
				odtReady_reg <= wlActive;
				exitHold_reg <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dqsTermOn <= 1'b0;
			dqTermOn <= 1'b0;
		end
		else if (ce)
		begin
			// strobe pair terminated once ODT accepted
			dqsTermOn <= wlActive ? (odtReady_reg & odtS) : odtS;
			dqTermOn <= wlActive ? 1'b0 : odtS;
		end
	end
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : laneGen
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					diff_reg[g] <= 1'b0;
					link.dqOut[g*8 +: 8] <= 8'h00;
					link.dqOeN[g] <= 1'b1;
				end
				else if (ce)
				begin
					diff_reg[g] <= dqsTS[g] & ~dqsCS[g];
					link.dqOeN[g] <= ~((wlActive & ~qOff) | exitHold_reg);
					// sample CK on strobe rise, level, per lane
					// all bits of the lane switch together, held
					if (wlActive && (dqsTS[g] & ~dqsCS[g]) && !diff_reg[g])
						link.dqOut[g*8 +: 8] <= {8{ckS}};
				end
			end
		end
	endgenerate
endmodule

// File: rtl/wlv_ctrl.sv
`timescale 1ns/1ns
module wlv_ctrl
	import wlv_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic otherQoff,
	wlv_if.ctrl link
);
	typedef enum logic [3:0]
	{
		S_IDLE = 4'h0,
		S_RTTWR = 4'h1,
		S_WMRD = 4'h3,
		S_ENTER = 4'h2,
		S_WMOD = 4'h6,
		S_DQSEN = 4'h7,
		S_WLMRD = 4'h5,
		S_PULSE = 4'h4,
		S_WLO = 4'hC,
		S_SAMPLE = 4'hD,
		S_ODTOFF = 4'hF,
		S_EXIT = 4'hE,
		S_WEXIT = 4'hA
	} wlv_state_t;
	wlv_state_t state_reg;
	logic [2:0] phase_reg;
	logic phaseEnd;
	logic [15:0] cnt_reg;
	logic [15:0] dqS;
	logic [LANES-1:0] fb;
	logic [LANES-1:0] prev_reg;
	logic [LANES-1:0] locked_reg;
	logic [DLY_W-1:0] delay_reg [LANES];
	logic [5:0] tries_reg;
	logic busy_reg, done_reg, fail_reg;
	logic startReq;
	function automatic logic [15:0] nckToCyc(input int n);
		nckToCyc = 16'(n * CK_PER_CYC);
	endfunction
	function automatic logic strobeWindow(input logic [15:0] remain, input logic [DLY_W-1:0] dly);
		strobeWindow = (nckToCyc(2) - 16'h0001 - remain) >= 16'(dly) &&
			(nckToCyc(2) - 16'h0001 - remain) < 16'(dly) + 16'(CK_HALF_CYC);
	endfunction
	assign phaseEnd = (phase_reg == 3'(CK_PER_CYC - 1));
	assign startReq = ce && regWr && regAddr == ADDR_CTRL && regWdata[CTRL_START_BIT];
	wlv_sync #(.W(16)) dqSync (.mclk(mclk), .rst(rst), .ce(ce), .d(link.dqLine), .q(dqS));
	assign fb = {dqS[8], dqS[0]};
	// Clock divider
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			phase_reg <= 3'h0;
			link.ck <= 1'b0;
		end
		else if (ce)
		begin
			phase_reg <= phaseEnd ? 3'h0 : phase_reg + 3'h1;
			link.ck <= phaseEnd | (phase_reg < 3'(CK_HALF_CYC - 1));
		end
	end
	// Sequencer
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			cnt_reg <= 16'h0000;
		end
		else if (ce)
		begin
			if (cnt_reg != 16'h0000)
				cnt_reg <= cnt_reg - 16'h0001;
			unique case (state_reg)
				S_IDLE:
					if (startReq)
						state_reg <= S_RTTWR;
				S_RTTWR:
					if (phaseEnd)
					begin
						state_reg <= S_WMRD;
						cnt_reg <= nckToCyc(T_MRD_NCK + 1);
					end
				S_WMRD:
					if (cnt_reg == 16'h0000 && phaseEnd)
						state_reg <= S_ENTER;
				S_ENTER:
					if (phaseEnd)
					begin
						state_reg <= S_WMOD;
						cnt_reg <= nckToCyc(T_MOD_NCK + 1);
					end
				S_WMOD:
					if (cnt_reg == 16'h0000)
					begin
						state_reg <= S_DQSEN;
						cnt_reg <= nckToCyc(T_WLDQSEN_NCK - T_MOD_NCK);
					end
				S_DQSEN:
					if (cnt_reg == 16'h0000)
					begin
						state_reg <= S_WLMRD;
						cnt_reg <= nckToCyc(T_WLMRD_NCK);
					end
				S_WLMRD:
					if (cnt_reg == 16'h0000 && phaseEnd)
					begin
						state_reg <= S_PULSE;
						cnt_reg <= nckToCyc(2) - 16'h0001;
					end
				S_PULSE:
					if (cnt_reg == 16'h0000)
					begin
						state_reg <= S_WLO;
						cnt_reg <= nckToCyc(T_WLO_NCK);
					end
				S_WLO:
					if (cnt_reg == 16'h0000)
						state_reg <= S_SAMPLE;
				S_SAMPLE:
					if (&locked_reg || tries_reg == 6'(MAX_TRIES))
					begin
						state_reg <= S_ODTOFF;
						cnt_reg <= nckToCyc(T_ODTOFF_NCK);
					end
					else
					begin
						state_reg <= S_WLMRD;
						cnt_reg <= nckToCyc(2);
					end
				S_ODTOFF:
					if (cnt_reg == 16'h0000 && phaseEnd)
						state_reg <= S_EXIT;
				S_EXIT:
					if (phaseEnd)
					begin
						state_reg <= S_WEXIT;
						cnt_reg <= nckToCyc(T_MOD_NCK + 1);
					end
				S_WEXIT:
					if (cnt_reg == 16'h0000)
						state_reg <= S_IDLE;
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end
	// only deselect or mode register writes
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			link.mrsCmd <= 1'b0;
			link.mrSel <= 3'h0;
			link.mrAddr <= 14'h0000;
		end
		else if (ce && phaseEnd)
		begin
			link.mrsCmd <= 1'b0;
			if (state_reg == S_RTTWR)
			begin
				link.mrsCmd <= 1'b1;
				link.mrSel <= MR_SEL_MR2;
				link.mrAddr <= MR2_BASE & ~(14'h0007 << MR2_RTTWR_POS);
			end
			else if (state_reg == S_ENTER || state_reg == S_EXIT)
			begin
				link.mrsCmd <= 1'b1;
				link.mrSel <= MR_SEL_MR1;
				link.mrAddr <= MR1_BASE;
				link.mrAddr[MR1_WL_BIT] <= (state_reg == S_ENTER);
			end
		end
	end
	// ODT after mode delay, low on exit
	always_ff @(posedge mclk)
	begin
		if (rst)
			link.odt <= 1'b0;
		else if (ce)
			link.odt <= state_reg inside {S_DQSEN, S_WLMRD, S_PULSE, S_WLO, S_SAMPLE};
	end
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : laneGen
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					link.dqsT[g] <= 1'b0;
					link.dqsC[g] <= 1'b0;
					link.dqsOeN[g] <= 1'b1;
					delay_reg[g] <= '0;
					prev_reg[g] <= 1'b1;
					locked_reg[g] <= 1'b0;
				end
				else if (ce)
				begin
					// park strobes, one edge per pulse
					link.dqsOeN[g] <= !(state_reg inside {S_WLMRD, S_PULSE, S_WLO, S_SAMPLE});
					link.dqsT[g] <= state_reg == S_PULSE && strobeWindow(cnt_reg, delay_reg[g]);
					link.dqsC[g] <= !(state_reg == S_PULSE && strobeWindow(cnt_reg, delay_reg[g]));
					if (state_reg == S_IDLE && startReq)
					begin
						delay_reg[g] <= '0;
						prev_reg[g] <= 1'b1;
						locked_reg[g] <= 1'b0;
					end
					else if (state_reg == S_SAMPLE && !locked_reg[g])
					begin
						prev_reg[g] <= fb[g];
						if (!prev_reg[g] && fb[g])
							locked_reg[g] <= 1'b1;
						else
							delay_reg[g] <= delay_reg[g] + DLY_W'(1);
					end
				end
			end
		end
	endgenerate
	// Status and register reads
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			tries_reg <= 6'h00;
			otherQoff <= 1'b0;
			regRdata <= 32'h00000000;
		end
		else if (ce)
		begin
			busy_reg <= state_reg != S_IDLE || startReq;
			otherQoff <= state_reg != S_IDLE;
			if (startReq && state_reg == S_IDLE)
			begin
				done_reg <= 1'b0;
				fail_reg <= 1'b0;
				tries_reg <= 6'h00;
			end
			else if (state_reg == S_SAMPLE)
			begin
				tries_reg <= tries_reg + 6'h01;
				fail_reg <= !(&locked_reg) && tries_reg == 6'(MAX_TRIES);
			end
			else if (state_reg == S_WEXIT && cnt_reg == 16'h0000)
				done_reg <= 1'b1;
			regRdata <= 32'h00000000;
			if (regRd && regAddr == ADDR_STATUS)
			begin
				regRdata[ST_BUSY_BIT] <= busy_reg;
				regRdata[ST_DONE_BIT] <= done_reg;
				regRdata[ST_FAIL_BIT] <= fail_reg;
			end
			else if (regRd && regAddr == ADDR_DELAY)
			begin
				regRdata[DLY_W-1:0] <= delay_reg[0];
				regRdata[DELAY_LANE_STRIDE +: DLY_W] <= delay_reg[1];
			end
		end
	end
endmodule

// File: tb/wlv_props.sv
`timescale 1ns/1ns
module wlv_props
	import wlv_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ck,
	input wire logic mrsCmd,
	input wire logic [2:0] mrSel,
	input wire logic [13:0] mrAddr,
	input wire logic odt,
	input wire logic [1:0] dqsT,
	input wire logic [1:0] dqsC,
	input wire logic [1:0] dqsOeN,
	input wire logic [1:0] dqsTLine,
	input wire logic [15:0] dqLine
);
	localparam int SLK = 2 * CK_PER_CYC;
	localparam int MOD_CYC = T_MOD_NCK * CK_PER_CYC - SLK;
	localparam int EN_CYC = T_WLDQSEN_NCK * CK_PER_CYC - SLK;
	localparam int OFF_CYC = T_ODTOFF_NCK * CK_PER_CYC - SLK;
	logic entry;
	logic leave;
	logic lvlReg;
	logic rttOffReg;
	int ageReg;
	int odtLowReg;
	assign entry = mrsCmd && mrSel == MR_SEL_MR1 && mrAddr[MR1_WL_BIT];
	assign leave = mrsCmd && mrSel == MR_SEL_MR1 && !mrAddr[MR1_WL_BIT];
	// Mode tracking
	always_ff @(posedge mclk)
	begin
		if (rst)
			lvlReg <= 1'b0;
		else if (entry || leave)
			lvlReg <= entry;
		if (rst)
			rttOffReg <= 1'b0;
		else if (mrsCmd && mrSel == MR_SEL_MR2)
			rttOffReg <= mrAddr[MR2_RTTWR_POS +: 3] == 3'h0;
	end
	// Elapsed time counters
	always_ff @(posedge mclk)
	begin
		ageReg <= (rst || entry) ? 0 : ageReg + 1;
		odtLowReg <= (rst || odt) ? 0 : odtLowReg + 1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rtt_off;
		entry |-> rttOffReg;
	endproperty
	property p_cmd;
		lvlReg && mrsCmd |-> mrSel == MR_SEL_MR1;
	endproperty
	property p_odt_on;
		$rose(odt) |-> lvlReg && ageReg >= MOD_CYC;
	endproperty
	property p_dqs_en;
		$fell(dqsOeN[0]) |-> lvlReg && ageReg >= EN_CYC;
	endproperty
	property p_diff;
		((dqsT ^ dqsC) | dqsOeN) == 2'h3;
	endproperty
	property p_fb_lo;
		$rose(dqsTLine[0]) |-> ##5 dqLine[7:0] == {8{$past(ck, 5)}};
	endproperty
	property p_fb_hi;
		$rose(dqsTLine[1]) |-> ##5 dqLine[15:8] == {8{$past(ck, 5)}};
	endproperty
	property p_uniform;
		dqLine[7:0] inside {8'h00, 8'hFF} && dqLine[15:8] inside {8'h00, 8'hFF};
	endproperty
	property p_exit;
		leave && lvlReg |-> !odt && dqsOeN == 2'h3 && odtLowReg >= OFF_CYC;
	endproperty
	a_rtt_off: assert property (p_rtt_off) else $error("entry with write termination");
	a_cmd: assert property (p_cmd) else $error("bad command in leveling");
	a_odt_on: assert property (p_odt_on) else $error("odt too early");
	a_dqs_en: assert property (p_dqs_en) else $error("strobe too early");
	a_diff: assert property (p_diff) else $error("strobe pair not complementary");
	a_fb_lo: assert property (p_fb_lo) else $error("lower lane feedback");
	a_fb_hi: assert property (p_fb_hi) else $error("upper lane feedback");
	a_uniform: assert property (p_uniform) else $error("lane bits differ");
	a_exit: assert property (p_exit) else $error("unclean exit");
	c_lock: cover property ($rose(dqLine[0]));
	c_hi: cover property ($rose(dqsTLine[1]));
	c_exit: cover property (leave && lvlReg);
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb
	import wlv_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic otherQoff, wlActive, qOff, dqsTermOn, dqTermOn;
	logic wlActiveB, qOffB;
	logic rdPend = 1'b0;
	logic [1:0] prevT = 2'h0;
	logic [1:0] fbCk = 2'h0;
	logic [1:0] fbPrev = 2'h3;
	int fbCnt[2] = '{0, 0};
	int pulses[2] = '{0, 0};
	int lockIdx[2] = '{-1, -1};
	int mismatches = 0;
	int testsRun = 0;
	int cyc = 0;
	int seed = 32'hA39F;
	logic [31:0] expQ[$];
	wlv_if lk();
	wlv_if lkB();
	wlv_ctrl i_wlv_ctrl (.mclk(mclk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .otherQoff(otherQoff), .link(lk.ctrl));
	wlv_dram i_wlv_dram (.mclk(mclk), .rst(rst), .ce(ce), .link(lk.dram), .wlActive(wlActive), .qOff(qOff),
		.dqsTermOn(dqsTermOn), .dqTermOn(dqTermOn));
	wlv_dram i_wlv_dram_b (.mclk(mclk), .rst(rst), .ce(ce), .link(lkB.dram), .wlActive(wlActiveB), .qOff(qOffB),
		.dqsTermOn(), .dqTermOn());
	wlv_props i_wlv_props (.mclk(mclk), .rst(rst), .ck(lk.ck), .mrsCmd(lk.mrsCmd), .mrSel(lk.mrSel),
		.mrAddr(lk.mrAddr), .odt(lk.odt), .dqsT(lk.dqsT), .dqsC(lk.dqsC), .dqsOeN(lk.dqsOeN),
		.dqsTLine(lk.dqsTLine), .dqLine(lk.dqLine));
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		lkB.ck = 1'b0;
		lkB.mrsCmd = 1'b0;
		lkB.mrSel = 3'h0;
		lkB.mrAddr = 14'h0000;
		lkB.odt = 1'b0;
		lkB.dqsT = 2'h0;
		lkB.dqsC = 2'h0;
		lkB.dqsOeN = 2'h3;
		#37;
		forever #80 lkB.ck = ~lkB.ck;
	end
	task automatic giveVerdict();
	begin
		if (mismatches == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		testsRun++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWdata <= d;
		if (!w)
			expQ.push_back(d);
		@(posedge mclk);
	end
	endtask
	function automatic logic watched(input int k);
	begin
		watched = (k == 0) ? wlActive : (k == 1) ? dqsTermOn : otherQoff;
	end
	endfunction
	task automatic waitFor(input int k, input logic v, input int lim);
		int n;
	begin
		n = 0;
		while (watched(k) !== v && n < lim)
		begin
			@(posedge mclk);
			n++;
		end
		chk({31'h0, watched(k)}, {31'h0, v});
	end
	endtask
	task automatic mrsB(input logic [2:0] s, input logic [13:0] a);
	begin
		@(negedge lkB.ck);
		@(posedge mclk);
		lkB.mrSel <= s;
		lkB.mrAddr <= a;
		lkB.mrsCmd <= 1'b1;
		@(negedge lkB.ck);
		@(posedge mclk);
		lkB.mrsCmd <= 1'b0;
		repeat (40) @(posedge mclk);
	end
	endtask
	// Read results, check feedback and hang limit
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			mismatches++;
			giveVerdict();
		end
	end
	always @(posedge mclk)
	begin
		if (rdPend)
			chk(regRdata, expQ.pop_front());
		rdPend <= regRd;
		for (int g = 0; g < LANES; g++)
		begin
			if (lk.dqsTLine[g] && !prevT[g])
			begin
				fbCk[g] = lk.ck;
				fbCnt[g] = 5;
			end
			else if (fbCnt[g] == 1)
			begin
				fbCnt[g] = 0;
				chk({24'h0, lk.dqLine[8*g +: 8]}, {24'h0, {8{fbCk[g]}}});
				if (fbCk[g] && !fbPrev[g] && lockIdx[g] < 0)
					lockIdx[g] = pulses[g];
				fbPrev[g] = fbCk[g];
				pulses[g]++;
			end
			else if (fbCnt[g] > 0)
				fbCnt[g]--;
		end
		prevT = lk.dqsTLine;
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, ADDR_STATUS, 32'h0);
		bus(1'b0, ADDR_DELAY, 32'h0);
		bus(1'b0, 8'h10 + 8'($unsigned($random(seed)) % 200), 32'h0);
		bus(1'b1, ADDR_DELAY, $random(seed));
		bus(1'b0, ADDR_DELAY, 32'h0);
		bus(1'b1, ADDR_CTRL, $random(seed) | 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h1);
		regRd <= 1'b0;
		waitFor(0, 1'b1, 400);
		chk({29'h0, otherQoff, qOff, dqTermOn}, 32'h4);
		waitFor(1, 1'b1, 1000);
		chk({30'h0, lk.odt, dqTermOn}, 32'h2);
		waitFor(2, 1'b0, 20000);
		bus(1'b0, ADDR_STATUS, 32'h2);
		bus(1'b0, ADDR_DELAY, {21'h0, 3'(lockIdx[1]), 5'h0, 3'(lockIdx[0])});
		ce <= 1'b0;
		bus(1'b1, ADDR_CTRL, 32'h1);
		ce <= 1'b1;
		bus(1'b0, ADDR_STATUS, 32'h2);
		regRd <= 1'b0;
		chk({31'h0, wlActive}, 32'h0);
		lkB.dqsOeN <= 2'h0;
		lkB.dqsT <= 2'h3;
		repeat (8) @(posedge mclk);
		chk({30'h0, lkB.dqOeN}, 32'h3);
		lkB.dqsOeN <= 2'h3;
		lkB.dqsT <= 2'h0;
		mrsB(MR_SEL_MR2, MR1_BASE | 14'h0080);
		chk({31'h0, wlActiveB}, 32'h0);
		mrsB(MR_SEL_MR1, MR1_BASE | 14'h1080);
		chk({28'h0, wlActiveB, qOffB, lkB.dqOeN}, 32'hF);
		mrsB(MR_SEL_MR1, MR1_BASE | 14'h0080);
		chk({28'h0, wlActiveB, qOffB, lkB.dqOeN}, 32'h8);
		mrsB(MR_SEL_MR1, MR1_BASE);
		chk({28'h0, wlActiveB, qOffB, lkB.dqOeN}, 32'h0);
		repeat (T_MOD_NCK * CK_PER_CYC) @(posedge mclk);
		chk({30'h0, lkB.dqOeN}, 32'h3);
		giveVerdict();
	end
endmodule
